//--- rtl/spfp_regs.vh
// register map, field layout and constants of the post-divider block
`ifndef SPFP_REGS_VH
`define SPFP_REGS_VH

`define SPFP_ADDR_W      8
`define SPFP_DATA_W      24
`define SPFP_PER_W       16
`define SPFP_NUM_CH      3

`define SPFP_S2C_OFS     8'h9E
`define SPFP_S2D_OFS     8'hA1
`define SPFP_S3A_OFS     8'hA4
`define SPFP_STAT_OFS    8'hF0

`define SPFP_CH_S2C      2'h0
`define SPFP_CH_S2D      2'h1
`define SPFP_CH_S3A      2'h2
`define SPFP_CH_NONE     2'h3

`define SPFP_CFG_RST     24'h000000
`define SPFP_SHAPE_HI    23
`define SPFP_SHAPE_LO    20
`define SPFP_SHAPE_FRAME 4'hF
`define SPFP_TYPE_BIT    19
`define SPFP_POL_BIT     18
`define SPFP_SEL_HI      17
`define SPFP_SEL_LO      16
`define SPFP_PER_HI      15
`define SPFP_PER_LO      0

`define SPFP_SEL_0       2'h0
`define SPFP_SEL_1       2'h1
`define SPFP_SEL_2       2'h2
`define SPFP_SEL_3       2'h3

`define SPFP_TYPE_MID    1'b0
`define SPFP_TYPE_EDGE   1'b1
`define SPFP_MIN_RATIO   24'h000002
`define SPFP_MAX_RATIO   24'hEFFFFF

`endif

//--- rtl/spfp_frame.v
// frame pulse generator timed by the edges of a related clock
`timescale 1ns/1ps
`include "spfp_regs.vh"

module spfp_frame #(
  parameter PER_W = `SPFP_PER_W
) (
  // clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_i,
  // control
  input  wire             restart_i,
  input  wire             enable_i,
  input  wire [PER_W-1:0] period_i,
  input  wire             type_i,
  // related clock level
  input  wire             rel_i,
  // pulse, before polarity
  output reg              pulse_o
);

  localparam [PER_W-1:0] ONE = {{(PER_W-1){1'b0}}, 1'b1};
  localparam [PER_W-1:0] ZERO = {PER_W{1'b0}};

  reg  [PER_W-1:0] cnt;
  reg              rel_q;
  wire             rise;
  wire             fall;
  wire             last;

  assign rise = rel_i & ~rel_q;
  assign fall = ~rel_i & rel_q;
  assign last = (cnt == period_i - ONE);

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rel_q <= 1'b0;
    end else begin
      rel_q <= rel_i;
    end
  end

  // period count of related-clock rising edges
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= ZERO;
    end else if (restart_i || !enable_i || period_i == ZERO) begin
      cnt <= ZERO;
    end else if (rise) begin
      cnt <= last ? ZERO : cnt + ONE;
    end
  end

  // pulse lasts one related period
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_o <= 1'b0;
    end else if (restart_i || !enable_i || period_i == ZERO) begin
      pulse_o <= 1'b0;
    end else if (type_i == `SPFP_TYPE_EDGE) begin
      if (rise) begin
        pulse_o <= last;
      end
    end else begin
      if (fall) begin
        pulse_o <= last;
      end
    end
  end

endmodule

//--- rtl/spfp_top.v
// post-divider outputs with clock and frame pulse shapes
// What this block does
// - shape code all ones selects frame pulse
// - otherwise clock divided by whole register, held low for ratios below 2, 50% for even ratios
// - low field counts related periods between pulses
// - selector picks sibling; width one related period
// - divider C selector: A, B, reserved, D
// - divider D selector: A, B, C, reserved
// - polarity bit zero regular, one inverted
// - type zero: boundary mid-pulse
// - type one: boundary on pulse edge
// - each divider divides the shared sys_clk_i
`timescale 1ns/1ps
`include "spfp_regs.vh"

module spfp_top #(
  parameter ADDR_W = `SPFP_ADDR_W,
  parameter DATA_W = `SPFP_DATA_W,
  parameter PER_W  = `SPFP_PER_W
) (
  // clock and reset
  input  wire              sys_clk_i,
  input  wire              rst_i,
  // register port
  input  wire [ADDR_W-1:0] addr_i,
  input  wire [DATA_W-1:0] wr_data_i,
  input  wire              wr_en_i,
  input  wire              rd_en_i,
  output reg  [DATA_W-1:0] rd_data_o,
  // sibling divider clocks outside this block
  input  wire              synth_two_a_clk_i,
  input  wire              synth_two_b_clk_i,
  input  wire              synth_three_b_clk_i,
  input  wire              synth_three_c_clk_i,
  input  wire              synth_three_d_clk_i,
  // divider outputs
  output wire              synth_two_divider_c_value_o,
  output wire              synth_two_divider_d_value_o,
  output wire              synth_three_divider_a_value_o
);

  localparam NCH = `SPFP_NUM_CH;
  localparam [DATA_W-1:0] ONE  = {{(DATA_W-1){1'b0}}, 1'b1};
  localparam [DATA_W-1:0] ZERO = {DATA_W{1'b0}};

  // address to channel index
  function [1:0] spfp_decode;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `SPFP_S2C_OFS: spfp_decode = `SPFP_CH_S2C;
        `SPFP_S2D_OFS: spfp_decode = `SPFP_CH_S2D;
        `SPFP_S3A_OFS: spfp_decode = `SPFP_CH_S3A;
        default:       spfp_decode = `SPFP_CH_NONE;
      endcase
    end
  endfunction

  // four-way related clock choice
  function spfp_pick;
    input [1:0] s;
    input       v0;
    input       v1;
    input       v2;
    input       v3;
    begin
      case (s)
        `SPFP_SEL_0: spfp_pick = v0;
        `SPFP_SEL_1: spfp_pick = v1;
        `SPFP_SEL_2: spfp_pick = v2;
        `SPFP_SEL_3: spfp_pick = v3;
        default:     spfp_pick = 1'b0;
      endcase
    end
  endfunction

  // selector value naming no usable clock
  function spfp_bad_sel;
    input [1:0] ch;
    input [1:0] s;
    begin
      case (ch)
        `SPFP_CH_S2C: spfp_bad_sel = (s == `SPFP_SEL_2);
        `SPFP_CH_S2D: spfp_bad_sel = (s == `SPFP_SEL_3);
        `SPFP_CH_S3A: spfp_bad_sel = (s == `SPFP_SEL_0);
        default:      spfp_bad_sel = 1'b0;
      endcase
    end
  endfunction

  wire [1:0]            wr_idx;
  wire [1:0]            rd_idx;
  wire                  stat_hit;
  reg  [NCH*DATA_W-1:0] cfg_all;
  reg  [NCH-1:0]        load_q;
  wire [NCH-1:0]        frame_mode;
  wire [NCH-1:0]        rel_clk;
  wire [NCH-1:0]        bad_sel;
  reg  [NCH-1:0]        out_q;
  wire [DATA_W-1:0]     status;
  reg  [DATA_W-1:0]     next_rd_data;

  assign wr_idx   = spfp_decode(addr_i);
  assign rd_idx   = spfp_decode(addr_i);
  assign stat_hit = (addr_i == `SPFP_STAT_OFS);

  assign synth_two_divider_c_value_o   = out_q[`SPFP_CH_S2C];
  assign synth_two_divider_d_value_o   = out_q[`SPFP_CH_S2D];
  assign synth_three_divider_a_value_o = out_q[`SPFP_CH_S3A];

  // related clock selection per channel
  assign rel_clk[`SPFP_CH_S2C] = spfp_pick(
    cfg_all[`SPFP_CH_S2C*DATA_W+`SPFP_SEL_HI -: 2],
    synth_two_a_clk_i,
    synth_two_b_clk_i,
    1'b0,
    out_q[`SPFP_CH_S2D]);

  assign rel_clk[`SPFP_CH_S2D] = spfp_pick(
    cfg_all[`SPFP_CH_S2D*DATA_W+`SPFP_SEL_HI -: 2],
    synth_two_a_clk_i,
    synth_two_b_clk_i,
    out_q[`SPFP_CH_S2C],
    1'b0);

  assign rel_clk[`SPFP_CH_S3A] = spfp_pick(
    cfg_all[`SPFP_CH_S3A*DATA_W+`SPFP_SEL_HI -: 2],
    1'b0,
    synth_three_b_clk_i,
    synth_three_c_clk_i,
    synth_three_d_clk_i);

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      localparam [1:0]  IDX = g;
      wire [DATA_W-1:0] cfg;
      wire [DATA_W-1:0] ratio;
      wire [DATA_W-1:0] half;
      wire              run_div;
      wire              pulse;
      reg  [DATA_W-1:0] div_cnt;
      reg  [DATA_W-1:0] next_div_cnt;
      reg               div_clk;

      assign cfg   = cfg_all[g*DATA_W +: DATA_W];
      assign ratio = cfg;
      assign half  = ratio >> 1;

      assign frame_mode[g] =
        (cfg[`SPFP_SHAPE_HI:`SPFP_SHAPE_LO] == `SPFP_SHAPE_FRAME);

      assign bad_sel[g] = frame_mode[g] &&
        spfp_bad_sel(IDX, cfg[`SPFP_SEL_HI:`SPFP_SEL_LO]);

      assign run_div = !frame_mode[g] && (ratio >= `SPFP_MIN_RATIO);

      // register write and restart strobe
      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cfg_all[g*DATA_W +: DATA_W] <= `SPFP_CFG_RST;
          load_q[g]                   <= 1'b0;
        end else begin
          if (wr_en_i && wr_idx == IDX) begin
            cfg_all[g*DATA_W +: DATA_W] <= wr_data_i;
          end
          load_q[g] <= wr_en_i && (wr_idx == IDX);
        end
      end

      // normal divider counter
      always @* begin
        next_div_cnt = div_cnt + ONE;
        if (div_cnt >= ratio - ONE) begin
          next_div_cnt = ZERO;
        end
      end

      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          div_cnt <= ZERO;
          div_clk <= 1'b0;
        end else if (load_q[g] || !run_div) begin
          div_cnt <= ZERO;
          div_clk <= 1'b0;
        end else begin
          div_cnt <= next_div_cnt;
          div_clk <= (next_div_cnt < half);
        end
      end

      // frame pulse generator
      spfp_frame #(
        .PER_W (PER_W)
      ) u_frame (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .restart_i (load_q[g]),
        .enable_i  (frame_mode[g] && !bad_sel[g]),
        .period_i  (cfg[`SPFP_PER_HI:`SPFP_PER_LO]),
        .type_i    (cfg[`SPFP_TYPE_BIT]),
        .rel_i     (rel_clk[g]),
        .pulse_o   (pulse)
      );

      // output shape and polarity
      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          out_q[g] <= 1'b0;
        end else if (frame_mode[g]) begin
          out_q[g] <= pulse ^ cfg[`SPFP_POL_BIT];
        end else begin
          out_q[g] <= div_clk;
        end
      end
    end
  endgenerate

  // status: frame modes, output levels, unusable selectors
  assign status = {{(DATA_W-3*NCH){1'b0}}, bad_sel, out_q, frame_mode};

  // read data stands one cycle after the strobe only
  always @* begin
    next_rd_data = ZERO;
    if (rd_en_i) begin
      if (stat_hit) begin
        next_rd_data = status;
      end else if (rd_idx != `SPFP_CH_NONE) begin
        next_rd_data = cfg_all[rd_idx*DATA_W +: DATA_W];
      end
    end
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= ZERO;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

endmodule

//--- verif/spfp_sib_model.sv
// sibling divider clocks of both synthesizers
`timescale 1ns/1ps
module spfp_sib_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // levels: periods 4, 6, 8, 10, 12 cycles
  output logic      [4:0] sib_o
);
  logic [2:0] cnt [5];
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 5; i++) begin
        cnt[i] <= 3'h0;
        sib_o[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (cnt[i] == 3'(i + 1)) begin
          cnt[i] <= 3'h0;
          sib_o[i] <= ~sib_o[i];
        end else begin
          cnt[i] <= cnt[i] + 3'h1;
        end
      end
    end
  end
endmodule

//--- verif/spfp_top_monitor.sv
// assertions on register port and divider outputs
`timescale 1ns/1ps
module spfp_top_monitor (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // register port
  input wire logic [7:0]  addr_i,
  input wire logic [23:0] wr_data_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [23:0] rd_data_o,
  // outputs
  input wire logic        synth_two_divider_c_value_o,
  input wire logic        synth_two_divider_d_value_o,
  input wire logic        synth_three_divider_a_value_o
);
  logic [23:0] c, d, a, exp_rd;
  logic [2:0]  sw;
  logic        rd_p, rd_v, co, do_, ao;
  assign co = synth_two_divider_c_value_o;
  assign do_ = synth_two_divider_d_value_o;
  assign ao = synth_three_divider_a_value_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {c, d, a, exp_rd, sw, rd_p, rd_v} <= '0;
    end else begin
      if (wr_en_i && addr_i == 8'h9E) c <= wr_data_i;
      if (wr_en_i && addr_i == 8'hA1) d <= wr_data_i;
      if (wr_en_i && addr_i == 8'hA4) a <= wr_data_i;
      sw <= wr_en_i ? 3'h0 : (sw == 3'h7 ? sw : sw + 3'h1);
      rd_p <= rd_en_i;
      rd_v <= rd_en_i && addr_i != 8'hF0;
      exp_rd <= addr_i == 8'h9E ? c : addr_i == 8'hA1 ? d :
                addr_i == 8'hA4 ? a : 24'h000000;
    end
  end
  property p_rd_idle;
    !rd_p |-> rd_data_o == 24'h000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_rd_map;
    rd_v |-> rd_data_o == exp_rd;
  endproperty
  a_rd_map: assert property (p_rd_map)
    else $error("read data wrong");
  property p_stop;
    sw == 3'h7 && c < 24'h000002 |-> !co;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopped divider runs");
  property p_div2;
    sw == 3'h7 && c == 24'h000002 |-> co != $past(co);
  endproperty
  a_div2: assert property (p_div2)
    else $error("ratio two wrong");
  property p_div4;
    sw == 3'h7 && c == 24'h000004 && $fell(co) |->
      $past(co, 1) && $past(co, 2) && !$past(co, 3) && !$past(co, 4);
  endproperty
  a_div4: assert property (p_div4)
    else $error("ratio four wrong");
  property p_c_rsv;
    sw == 3'h7 && c[23:16] == 8'hF2 |-> co == c[18];
  endproperty
  a_c_rsv: assert property (p_c_rsv)
    else $error("C reserved pulses");
  property p_d_rsv;
    sw == 3'h7 && d[23:20] == 4'hF && d[17:16] == 2'h3 |-> do_ == d[18];
  endproperty
  a_d_rsv: assert property (p_d_rsv)
    else $error("D reserved pulses");
  property p_a_rsv;
    sw == 3'h7 && a[23:20] == 4'hF && a[17:16] == 2'h0 |-> ao == a[18];
  endproperty
  a_a_rsv: assert property (p_a_rsv)
    else $error("A reserved pulses");
  property p_zero;
    sw == 3'h7 && c[23:20] == 4'hF && c[15:0] == 16'h0000 |-> co == c[18];
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero period pulses");
endmodule
bind spfp_top spfp_top_monitor mon (
  .sys_clk_i                     (sys_clk_i),
  .rst_i                         (rst_i),
  .addr_i                        (addr_i),
  .wr_data_i                     (wr_data_i),
  .wr_en_i                       (wr_en_i),
  .rd_en_i                       (rd_en_i),
  .rd_data_o                     (rd_data_o),
  .synth_two_divider_c_value_o   (synth_two_divider_c_value_o),
  .synth_two_divider_d_value_o   (synth_two_divider_d_value_o),
  .synth_three_divider_a_value_o (synth_three_divider_a_value_o)
);

//--- verif/spfp_top_test.sv
// self-checking bench for the post-divider block
`timescale 1ns/1ps
module spfp_top_test;
  logic        sys_clk_i, rst_i, wr_en_i, rd_en_i;
  logic [7:0]  addr_i;
  logic [23:0] wr_data_i;
  wire  [23:0] rd_data_o;
  wire  [4:0]  sib;
  wire  [2:0]  o;
  int          num_errors = 0;
  int          comparisons = 0;
  spfp_sib_model sm (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sib_o(sib));
  spfp_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .synth_two_a_clk_i(sib[0]),
    .synth_two_b_clk_i(sib[1]), .synth_three_b_clk_i(sib[2]),
    .synth_three_c_clk_i(sib[3]), .synth_three_d_clk_i(sib[4]),
    .synth_two_divider_c_value_o(o[0]), .synth_two_divider_d_value_o(o[1]),
    .synth_three_divider_a_value_o(o[2]));
  task stop_test;
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, g);
    comparisons++;
    if (e !== g) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tk;
    @(posedge sys_clk_i);
    #1;
  endtask
  task wr(input logic [7:0] ad, input logic [23:0] dt);
    @(posedge sys_clk_i);
    {wr_en_i, addr_i, wr_data_i} <= {1'b1, ad, dt};
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [23:0] e);
    @(posedge sys_clk_i);
    {rd_en_i, addr_i} <= {1'b1, ad};
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    #1 chk("read", e, rd_data_o);
  endtask
  task automatic wt(input int ix, input logic lv, output int n);
    n = 0;
    while (o[ix] === lv && n < 300) begin
      tk();
      n++;
    end
  endtask
  task automatic run(input logic [7:0] ad, input logic [23:0] dt,
                     input int ix, input logic lv, input int w, s);
    int n, m;
    wr(ad, dt);
    rd(ad, dt);
    if (w == 0) begin
      repeat (40) tk();
      chk("level", 24'(lv), 24'(o[ix]));
    end else begin
      repeat (2) wt(ix, !lv, n);
      wt(ix, lv, n);
      wt(ix, !lv, n);
      wt(ix, lv, n);
      wt(ix, !lv, m);
      chk("width", 24'(w), 24'(n));
      chk("period", 24'(s), 24'(n + m));
    end
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end
  initial begin
    {rst_i, wr_en_i, rd_en_i, addr_i, wr_data_i} = {1'b1, 34'h0};
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(8'h9E, 24'h000000);
    rd(8'hA1, 24'h000000);
    rd(8'hA4, 24'h000000);
    rd(8'h00, 24'h000000);
    run(8'h9E, 24'h000004, 0, 1'b1, 2, 4);
    run(8'h9E, 24'h000002, 0, 1'b1, 1, 2);
    run(8'h9E, 24'h000001, 0, 1'b0, 0, 0);
    run(8'hA1, 24'h000006, 1, 1'b1, 3, 6);
    run(8'hA4, 24'h000005, 2, 1'b1, 2, 5);
    run(8'h9E, 24'hF80003, 0, 1'b1, 4, 12);
    run(8'h9E, 24'hF10002, 0, 1'b1, 6, 12);
    run(8'h9E, 24'hF30002, 0, 1'b1, 6, 12);
    run(8'h9E, 24'hF20002, 0, 1'b0, 0, 0);
    run(8'h9E, 24'hF80000, 0, 1'b0, 0, 0);
    run(8'h9E, 24'hEFFFFF, 0, 1'b1, 0, 0);
    run(8'h9E, 24'h000004, 0, 1'b1, 2, 4);
    run(8'hA1, 24'hFE0003, 1, 1'b0, 4, 12);
    run(8'hA1, 24'hF00003, 1, 1'b1, 4, 12);
    run(8'hA1, 24'hF10002, 1, 1'b1, 6, 12);
    run(8'hA1, 24'hF70002, 1, 1'b1, 0, 0);
    run(8'hA4, 24'hF90002, 2, 1'b1, 8, 16);
    run(8'hA4, 24'hF60002, 2, 1'b0, 10, 20);
    run(8'hA4, 24'hF30002, 2, 1'b1, 12, 24);
    run(8'hA4, 24'hF40002, 2, 1'b1, 0, 0);
    run(8'h9E, 24'h000001, 0, 1'b0, 0, 0);
    rd(8'hF0, 24'h0001B6);
    wr(8'h9F, 24'hFFFFFF);
    wr(8'hF0, 24'h000000);
    rd(8'hF0, 24'h0001B6);
    rd(8'h9E, 24'h000001);
    stop_test;
  end
endmodule
